/* File: verilog/stamp_defines.svh */
`ifndef STAMP_DEFINES_SVH
`define STAMP_DEFINES_SVH

// clock rate and length of one lifetime hour in its own unit
`define STAMP_CLK_HZ 64'h2625A00
`define STAMP_HOUR_SEC 64'hE10

// low nibble of the state byte
`define STATE_UNKNOWN 4'h0
`define STATE_SLEEP 4'h1
`define STATE_STANDBY 4'h2
`define STATE_ACTIVE_IDLE 4'h3
`define STATE_OFFLINE 4'h4
`define STATE_LAST_LEGAL 4'h4

// byte offsets inside an error entry
`define ENTRY_OFS_STATE 6'h1F
`define ENTRY_OFS_STAMP_LSB 6'h20
`define ENTRY_OFS_STAMP_MSB 6'h21

// reset values
`define ENTRY_RESET_BYTE 8'h00
`define ENTRY_RESET_WORD 16'h0000

`endif

/* File: verilog/stamp_pkg.sv */
package stamp_pkg;

    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STANDBY = 2'b10,
        MODE_SLEEP = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        TRK_IDLE = 2'b00,
        TRK_HELD = 2'b01,
        TRK_STAMPED = 2'b10
    } track_e;

    typedef logic [3:0] state_code_t;

endpackage : stamp_pkg

/* File: verilog/state_encoder.sv */
`timescale 1ns/1ps
`include "stamp_defines.svh"

module state_encoder
    import stamp_pkg::*;
#(
    parameter logic [3:0] VENDOR_HI = 4'h0
) (
    // device condition
    input wire mode_e power_mode,
    input wire logic busy,
    input wire logic offline_run,
    input wire logic by_reset,
    // encoded state byte
    output logic [7:0] code
);

    wire is_offline = offline_run;
    // a command cannot be accepted asleep, so sleep is only reported for a reset
    wire is_sleep = (power_mode == MODE_SLEEP) && by_reset;
    wire is_standby = (power_mode == MODE_STANDBY);
    wire is_act_idle = ((power_mode == MODE_ACTIVE) || (power_mode == MODE_IDLE)) && !busy;

    wire state_code_t low = is_offline ? `STATE_OFFLINE :
                            is_sleep ? `STATE_SLEEP :
                            is_standby ? `STATE_STANDBY :
                            is_act_idle ? `STATE_ACTIVE_IDLE :
                            `STATE_UNKNOWN;

    assign code = {VENDOR_HI, low};

endmodule : state_encoder

/* File: verilog/hour_counter.sv */
`timescale 1ns/1ps
`include "stamp_defines.svh"

module hour_counter #(
    parameter longint unsigned CYCLES_PER_HOUR = `STAMP_CLK_HZ * `STAMP_HOUR_SEC,
    parameter int HOURS_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // lifetime carried over from earlier power-on periods
    input wire logic [HOURS_W-1:0] hours_init,
    // elapsed powered hours
    output logic [HOURS_W-1:0] hours
);

    localparam int PW = $clog2(CYCLES_PER_HOUR + 64'h1);
    localparam logic [PW-1:0] LAST = PW'(CYCLES_PER_HOUR - 64'h1);

    logic [PW-1:0] prescale;
    wire hour_tick = (prescale == LAST);
    wire at_max = &hours;

    generate
        if (CYCLES_PER_HOUR < 64'h1 || HOURS_W < 2) begin : g_bad_param
            $error("hour_counter: unusable parameters");
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prescale <= '0;
        end else begin
            prescale <= hour_tick ? '0 : prescale + PW'(1);
        end
    end

    // saturate rather than wrap so an old drive never looks new
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hours <= hours_init;
        end else if (hour_tick && !at_max) begin
            hours <= hours + HOURS_W'(1);
        end
    end

endmodule : hour_counter

/* File: verilog/error_log_state_stamp.sv */
`timescale 1ns/1ps
`include "stamp_defines.svh"

// Function
// - entry state records device condition at command write or reset arrival
// - low nibble codes 0 unknown, 1 sleep, 2 standby, 3 active/idle not busy
// - code 4 means off-line collection or self-test; 5 to 15 never produced
// - high nibble is free per state; only low nibble is checked
// - sleep code used for a reset received while asleep
// - standby code used for command or reset received in standby
// - active/idle code only when active or idle and busy clear
// - off-line code when off-line collection or self-test was running
// - timestamp holds powered-on lifetime hours at command completion, or at arrival for a reset
// - logged register word: low byte normal view, high byte previous view
// - timestamp stored low byte at lower offset, high byte next

module error_log_state_stamp
    import stamp_pkg::*;
#(
    parameter longint unsigned CYCLES_PER_HOUR = `STAMP_CLK_HZ * `STAMP_HOUR_SEC,
    parameter int HOURS_W = 16,
    parameter logic [3:0] VENDOR_HI = 4'h0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // device condition
    input wire mode_e power_mode,
    input wire logic busy,
    input wire logic offline_run,
    // events
    input wire logic cmd_written,
    input wire logic reset_arrived,
    input wire logic cmd_done,
    input wire logic cmd_failed,
    input wire logic log_commit,
    // register views at command write
    input wire logic [7:0] reg_lo_byte,
    input wire logic [7:0] reg_hi_byte,
    // lifetime
    input wire logic [HOURS_W-1:0] hours_init,
    output logic [HOURS_W-1:0] power_on_hours,
    // finished entry fields
    output logic [7:0] entry_state,
    output logic [7:0] entry_stamp_lsb,
    output logic [7:0] entry_stamp_msb,
    output logic [15:0] entry_reg_word,
    output logic entry_ready,
    output logic pending,
    // entry byte readout
    input wire logic [5:0] entry_ofs,
    output logic [7:0] entry_byte
);

    generate
        if (HOURS_W < 9 || HOURS_W > 16) begin : g_bad_width
            $error("error_log_state_stamp: HOURS_W must be 9 to 16");
        end
    endgenerate

    track_e state;
    track_e next_state;
    logic [7:0] held_code;
    logic [15:0] held_reg;
    logic [HOURS_W-1:0] held_hours;
    logic [HOURS_W-1:0] hours;
    logic [7:0] live_code;

    hour_counter #(
        .CYCLES_PER_HOUR(CYCLES_PER_HOUR),
        .HOURS_W(HOURS_W)
    ) hour_counter_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .hours_init(hours_init),
        .hours(hours)
    );

    // the encoder sees whether the event is a reset so sleep is only used for it
    state_encoder #(
        .VENDOR_HI(VENDOR_HI)
    ) state_encoder_i (
        .power_mode(power_mode),
        .busy(busy),
        .offline_run(offline_run),
        .by_reset(reset_arrived),
        .code(live_code)
    );

    // event decode; reset beats completion, completion beats a new write
    wire is_idle = (state == TRK_IDLE);
    wire is_held = (state == TRK_HELD);
    wire is_stamped = (state == TRK_STAMPED);
    wire rst_take = reset_arrived && !is_stamped;
    wire done_take = is_held && !reset_arrived && cmd_done;
    wire fail_take = done_take && cmd_failed;
    wire write_take = cmd_written && !reset_arrived && (is_idle || (is_held && !cmd_done));
    wire cap_en = rst_take || write_take;
    // a reset has no completion of its own, so it is stamped on arrival
    wire stamp_en = rst_take || fail_take;
    wire publish = is_stamped && log_commit;

    always_comb begin
        next_state = state;
        case (state)
            TRK_IDLE: begin
                if (rst_take) begin
                    next_state = TRK_STAMPED;
                end else if (write_take) begin
                    next_state = TRK_HELD;
                end
            end
            TRK_HELD: begin
                if (rst_take || fail_take) begin
                    next_state = TRK_STAMPED;
                end else if (done_take) begin
                    next_state = TRK_IDLE;
                end
            end
            TRK_STAMPED: begin
                if (publish) begin
                    next_state = TRK_IDLE;
                end
            end
            default: begin
                next_state = TRK_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= TRK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture at the write or reset edge, recapture on a later one while held, and freeze once stamped until published
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_code <= `ENTRY_RESET_BYTE;
        end else if (cap_en) begin
            held_code <= live_code;
        end
    end

    // a reset carries no register snapshot of its own
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_reg <= `ENTRY_RESET_WORD;
        end else if (write_take) begin
            held_reg <= {reg_hi_byte, reg_lo_byte};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_hours <= '0;
        end else if (stamp_en) begin
            held_hours <= hours;
        end
    end

    wire [15:0] stamp_word = 16'(held_hours);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            entry_state <= `ENTRY_RESET_BYTE;
            entry_stamp_lsb <= `ENTRY_RESET_BYTE;
            entry_stamp_msb <= `ENTRY_RESET_BYTE;
            entry_reg_word <= `ENTRY_RESET_WORD;
        end else if (publish) begin
            entry_state <= held_code;
            entry_stamp_lsb <= stamp_word[7:0];
            entry_stamp_msb <= stamp_word[15:8];
            entry_reg_word <= held_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            entry_ready <= 1'b0;
            pending <= 1'b0;
        end else begin
            entry_ready <= publish;
            pending <= (next_state == TRK_STAMPED);
        end
    end

    // lower offset carries the low stamp byte
    wire [7:0] ofs_byte = (entry_ofs == `ENTRY_OFS_STATE) ? entry_state :
                          (entry_ofs == `ENTRY_OFS_STAMP_LSB) ? entry_stamp_lsb :
                          (entry_ofs == `ENTRY_OFS_STAMP_MSB) ? entry_stamp_msb :
                          `ENTRY_RESET_BYTE;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            entry_byte <= `ENTRY_RESET_BYTE;
        end else begin
            entry_byte <= ofs_byte;
        end
    end

    assign power_on_hours = hours;

    // checks
    wire act_idle_ok = ((power_mode == MODE_ACTIVE) || (power_mode == MODE_IDLE)) && !busy;
    wire [7:0] stamp_hi = stamp_word[15:8];

    sequence s_capture;
        cap_en;
    endsequence

    sequence s_commit;
        is_stamped && log_commit;
    endsequence

    sequence s_fail_done;
        is_held && cmd_done && cmd_failed && !reset_arrived;
    endsequence

    sequence s_reset_take;
        rst_take;
    endsequence

    AST_SLEEP: assert property (@(posedge ref_clk) disable iff (reset)
        s_capture and (reset_arrived && power_mode == MODE_SLEEP && !offline_run)
        |=> held_code[3:0] == `STATE_SLEEP)
        else $error("sleep reset not logged as sleep");

    AST_STANDBY: assert property (@(posedge ref_clk) disable iff (reset)
        s_capture and (power_mode == MODE_STANDBY && !offline_run)
        |=> held_code[3:0] == `STATE_STANDBY)
        else $error("standby event not logged as standby");

    AST_ACTIVE: assert property (@(posedge ref_clk) disable iff (reset)
        s_capture |=> (held_code[3:0] == `STATE_ACTIVE_IDLE) == ($past(act_idle_ok) && !$past(offline_run)))
        else $error("active/idle code disagrees with mode and busy");

    AST_OFFLINE: assert property (@(posedge ref_clk) disable iff (reset)
        s_capture and offline_run |=> held_code[3:0] == `STATE_OFFLINE)
        else $error("off-line activity not logged");

    AST_NO_RESERVED: assert property (@(posedge ref_clk) disable iff (reset)
        held_code[3:0] <= `STATE_LAST_LEGAL && entry_state[3:0] <= `STATE_LAST_LEGAL)
        else $error("reserved state code produced");

    AST_UNKNOWN: assert property (@(posedge ref_clk) disable iff (reset)
        s_capture and (busy && !offline_run && power_mode == MODE_ACTIVE)
        |=> held_code[3:0] == `STATE_UNKNOWN)
        else $error("busy active command not logged as unknown");

    AST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        is_stamped && !log_commit |=> $stable(held_code) && $stable(held_hours) && is_stamped)
        else $error("held entry changed before commit");

    AST_PUBLISH: assert property (@(posedge ref_clk) disable iff (reset)
        s_commit |=> entry_ready && entry_state == $past(held_code) ##1 !entry_ready)
        else $error("entry not published from held state");

    AST_STAMP: assert property (@(posedge ref_clk) disable iff (reset)
        s_fail_done |=> is_stamped && held_hours == $past(hours))
        else $error("timestamp not taken at completion");

    AST_SPLIT: assert property (@(posedge ref_clk) disable iff (reset)
        write_take |=> held_reg == {$past(reg_hi_byte), $past(reg_lo_byte)})
        else $error("register word split wrong");

    AST_STAMP_ORDER: assert property (@(posedge ref_clk) disable iff (reset)
        s_commit ##1 (entry_ofs == `ENTRY_OFS_STAMP_MSB)
        |=> entry_byte == $past(stamp_hi, 2))
        else $error("stamp high byte at wrong offset");

    // both roads into a stamped entry, and what may leave it
    AST_RESET_STAMP: assert property (@(posedge ref_clk) disable iff (reset)
        s_reset_take |=> is_stamped && pending && held_hours == $past(hours))
        else $error("reset event not stamped on arrival");

    AST_PENDING_SET: assert property (@(posedge ref_clk) disable iff (reset)
        s_fail_done |=> pending)
        else $error("failed command not left pending");

    AST_PASS_DROP: assert property (@(posedge ref_clk) disable iff (reset)
        done_take && !cmd_failed |=> is_idle && !pending)
        else $error("successful command kept for logging");

    AST_COMMIT_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        s_commit |=> is_idle && !pending)
        else $error("pending not cleared by commit");

    AST_NO_STRAY: assert property (@(posedge ref_clk) disable iff (reset)
        !publish |=> !entry_ready)
        else $error("entry ready without commit");

    AST_STATE_BYTE: assert property (@(posedge ref_clk) disable iff (reset)
        entry_ofs == `ENTRY_OFS_STATE |=> entry_byte == $past(entry_state))
        else $error("state byte not at its offset");

    AST_STAMP_LSB: assert property (@(posedge ref_clk) disable iff (reset)
        entry_ofs == `ENTRY_OFS_STAMP_LSB |=> entry_byte == $past(entry_stamp_lsb))
        else $error("stamp low byte at wrong offset");

endmodule : error_log_state_stamp

/* File: bench/log_reader.sv */
`timescale 1ns/1ps

module log_reader (
    // clock
    input wire logic ref_clk,
    // entry readout
    input wire logic [7:0] entry_byte,
    output logic [5:0] entry_ofs
);
    // idle offset points at an unused byte, so a stale read shows 00
    initial entry_ofs = 6'h00;

    // called at a falling edge; the byte stands one rising edge later
    // trailing edge keeps back-to-back reads from moving the offset twice at once
    task automatic read(input logic [5:0] ofs, output logic [7:0] b);
        entry_ofs = ofs;
        @(negedge ref_clk);
        b = entry_byte;
        entry_ofs = 6'h00;
        @(negedge ref_clk);
    endtask : read
endmodule : log_reader

/* File: bench/error_log_state_stamp_test.sv */
`timescale 1ns/1ps

module error_log_state_stamp_test;
    import stamp_pkg::*;
    logic ref_clk, reset, busy, offline_run, cmd_written, reset_arrived;
    logic cmd_done, cmd_failed, log_commit, entry_ready, pending;
    mode_e power_mode;
    logic [7:0] reg_lo_byte, reg_hi_byte, entry_state, entry_stamp_lsb, entry_stamp_msb, entry_byte;
    logic [15:0] hours_init, power_on_hours, entry_reg_word;
    logic [5:0] entry_ofs;
    int err_count = 0, n_compared = 0, cyc = 0, ticks = 0;

    error_log_state_stamp #(.CYCLES_PER_HOUR(16), .HOURS_W(16), .VENDOR_HI(4'hA)) error_log_state_stamp_i (
        .ref_clk(ref_clk), .reset(reset), .power_mode(power_mode), .busy(busy),
        .offline_run(offline_run), .cmd_written(cmd_written), .reset_arrived(reset_arrived),
        .cmd_done(cmd_done), .cmd_failed(cmd_failed), .log_commit(log_commit),
        .reg_lo_byte(reg_lo_byte), .reg_hi_byte(reg_hi_byte), .hours_init(hours_init),
        .power_on_hours(power_on_hours), .entry_state(entry_state),
        .entry_stamp_lsb(entry_stamp_lsb), .entry_stamp_msb(entry_stamp_msb),
        .entry_reg_word(entry_reg_word), .entry_ready(entry_ready), .pending(pending),
        .entry_ofs(entry_ofs), .entry_byte(entry_byte));

    log_reader log_reader_i (.ref_clk(ref_clk), .entry_byte(entry_byte), .entry_ofs(entry_ofs));

    initial begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task final_report();
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // cyc counts edges since reset release, the base of the expected hours
    always @(posedge ref_clk) begin
        ticks++;
        cyc = reset ? 0 : cyc + 1;
        if (ticks == 3000) begin
            err_count++;
            final_report();
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check

    task automatic pulse(ref logic s);
        s = 1;
        @(negedge ref_clk);
        s = 0;
    endtask : pulse

    task automatic wait_hi(ref logic s, input string m);
        for (int i = 0; i < 4 && s !== 1'b1; i++) @(negedge ref_clk);
        check(s, 1'b1, m);
    endtask : wait_hi

    task commit();
        wait_hi(pending, "pending");
        pulse(log_commit);
        wait_hi(entry_ready, "entry ready");
        check(pending, 1'b0, "pending cleared");
    endtask : commit

    task automatic log_event(input logic rst);
        if (rst) begin
            pulse(reset_arrived);
        end else begin
            pulse(cmd_written);
            @(negedge ref_clk);
            cmd_failed = 1;
            pulse(cmd_done);
            cmd_failed = 0;
        end
        commit();
    endtask : log_event

    task automatic state_table();
        mode_e md[8] = '{MODE_ACTIVE, MODE_IDLE, MODE_ACTIVE, MODE_STANDBY, MODE_STANDBY,
                         MODE_SLEEP, MODE_SLEEP, MODE_ACTIVE};
        logic [3:0] ex[8] = '{4'h3, 4'h3, 4'h0, 4'h2, 4'h2, 4'h1, 4'h0, 4'h4};
        logic [7:0] bz = 8'h84;
        logic [7:0] rs = 8'h32;
        for (int k = 0; k < 8; k++) begin
            power_mode = md[k];
            busy = bz[k];
            offline_run = (k == 7);
            log_event(rs[k]);
            check(entry_state[3:0], ex[k], "state code");
        end
    endtask : state_table

    task hold_state();
        power_mode = MODE_ACTIVE;
        busy = 0;
        offline_run = 0;
        pulse(cmd_written);
        power_mode = MODE_STANDBY;
        offline_run = 1;
        cmd_failed = 1;
        pulse(cmd_done);
        cmd_failed = 0;
        // arrives while pending, must not disturb the capture
        pulse(reset_arrived);
        commit();
        check(entry_state[3:0], 4'h3, "held state");
    endtask : hold_state

    task refusals();
        offline_run = 0;
        pulse(cmd_written);
        pulse(cmd_done);
        check(pending, 1'b0, "pending on success");
        pulse(log_commit);
        repeat (2) begin
            check(entry_ready, 1'b0, "stray entry");
            @(negedge ref_clk);
        end
        check(entry_state[3:0], 4'h3, "entry kept");
    endtask : refusals

    task stamp_word();
        logic [15:0] hrs;
        logic [7:0] b;
        reg_lo_byte = 8'hA5;
        reg_hi_byte = 8'h3C;
        pulse(cmd_written);
        reg_lo_byte = 8'h00;
        reg_hi_byte = 8'hFF;
        // aim mid-hour so a one-edge skew in the counter cannot matter
        while (cyc % 16 != 8) @(negedge ref_clk);
        hrs = 16'h01FF + 16'(cyc / 16);
        check(power_on_hours, hrs, "live hours");
        cmd_failed = 1;
        pulse(cmd_done);
        cmd_failed = 0;
        commit();
        check(entry_reg_word, 16'h3CA5, "register word");
        check(entry_stamp_lsb, hrs[7:0], "stamp lsb");
        check(entry_stamp_msb, hrs[15:8], "stamp msb");
        // high byte right after the commit so the offset check in the design is reached
        log_reader_i.read(6'h21, b);
        check(b, hrs[15:8], "byte 21");
        log_reader_i.read(6'h20, b);
        check(b, hrs[7:0], "byte 20");
        log_reader_i.read(6'h1F, b);
        check(b[3:0], 4'h2, "byte 1F");
    endtask : stamp_word

    initial begin
        reset = 1;
        power_mode = MODE_ACTIVE;
        {busy, offline_run, cmd_written, reset_arrived, cmd_done, cmd_failed, log_commit} = '0;
        reg_lo_byte = 8'h00;
        reg_hi_byte = 8'h00;
        hours_init = 16'h01FF;
        repeat (4) @(negedge ref_clk);
        reset = 0;
        state_table();
        hold_state();
        refusals();
        stamp_word();
        final_report();
    end
endmodule : error_log_state_stamp_test
